// ---- verilog/qs_pin_select.sv ----
`timescale 1ns/100ps
module qs_pin_select (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic regWrite,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input wire logic [1:0] videoMode,
    input wire logic fstLstTri,
    input wire logic qckTri,
    input wire logic resetSyncPin,
    input wire logic outDisablePin,
    output logic timingResync,
    output logic registerClear,
    output logic compositeDisable,
    output logic [1:0] driveStrength,
    input wire logic linkClk,
    input wire qs_pkg::qs_timing_type timing,
    output qs_pkg::qs_out_type pinsOut
);
    import qs_pkg::*;

    // Core domain state
    typedef struct packed {
        logic pinS1;
        logic pinS2;
        logic oebS1;
        logic oebS2;
        qs_modes_type modes;
        qs_pins_type pins;
        logic qckSet;
        logic [7:0] rdata;
        logic resync;
        logic clear;
        logic compDis;
        logic qckDis;
        logic [1:0] drive;
    } qs_core_type;

    // Link domain state
    typedef struct packed {
        logic fastQ;
        logic slowQ;
        logic prevData;
        logic prevVis;
        qs_still_type still;
        qs_out_type pins;
    } qs_link_type;

    qs_core_type core_reg, core_next;
    qs_link_type link_reg, link_next;
    qs_cfg_type srcCfg;
    qs_cfg_type cfg;
    logic regClear;
    logic lrS1_reg;
    logic lrS2_reg;
    logic linkRst;
    logic dataRise;
    logic visFall;
    logic stills;
    logic fieldStrobe;
    logic qckGate;
    logic qckClk;
    logic lineSel;

    // Default clock mode for a given video timing mode
    function automatic logic [1:0] qckDefault(input logic [1:0] vm);
        return (vm == VM_PALNTSC) ? QCK_FREE : QCK_OFF;
    endfunction : qckDefault

    // Register read decode, reserved space reads as zero
    function automatic logic [7:0] regRead(
        input logic [7:0] addr,
        input qs_modes_type m,
        input qs_pins_type p
    );
        logic [7:0] v;
        v = RSVD_VAL;
        if (addr == ADDR_MODES) begin
            v = m;
        end else if (addr == ADDR_PINS) begin
            v = p & PINS_WMASK;
        end
        return v;
    endfunction : regRead

    // Register clear from reset or the reset pin in reset mode
    // pin low clears
    assign regClear = rst | (~core_reg.pinS2 & ~core_reg.pins.sinEnable);

    // Core next state
    always_comb begin
        core_next = core_reg;
        core_next.pinS1 = resetSyncPin;
        core_next.pinS2 = core_reg.pinS1;
        core_next.oebS1 = outDisablePin;
        core_next.oebS2 = core_reg.oebS1;
        if (regClear) begin
            core_next.modes = MODES_RST;
            core_next.modes.qckMode = qckDefault(videoMode);
            core_next.pins = PINS_RST;
            core_next.qckSet = 1'b0;
        end else begin
            if (!core_reg.qckSet) begin
                core_next.modes.qckMode = qckDefault(videoMode);
            end
            if (regWrite && regAddr == ADDR_MODES) begin
                core_next.modes = regWdata;
                core_next.qckSet = 1'b1;
            end
            if (regWrite && regAddr == ADDR_PINS) begin
                core_next.pins = regWdata & PINS_WMASK;
            end
        end
        core_next.rdata = regRead(regAddr, core_reg.modes, core_reg.pins);
        core_next.resync = core_reg.pins.sinEnable ? core_reg.pinS2 :
            ~core_reg.pinS2;
        core_next.clear = regClear;
        core_next.compDis = core_reg.oebS2 | fstLstTri;
        core_next.qckDis = core_reg.oebS2 | qckTri;
        core_next.drive = core_reg.pins.drive;
    end

    // Core register, reset pin synchroniser idles high, disable pin synchroniser idles low
    always_ff @(posedge core_clk) begin
        if (rst) begin
            core_reg <= '{1'b1, 1'b1, 1'b0, 1'b0, MODES_RST, PINS_RST,
                1'b0, 8'h00, 1'b0, 1'b1, 1'b0, 1'b0, 2'h0};
        end else begin
            core_reg <= core_next;
        end
    end

    assign regRdata = core_reg.rdata;
    assign timingResync = core_reg.resync;
    assign registerClear = core_reg.clear;
    assign compositeDisable = core_reg.compDis;
    assign driveStrength = core_reg.drive;

    // Configuration word sent to the link side
    always_comb begin
        srcCfg.modes = core_reg.modes;
        srcCfg.ovrEn = core_reg.pins.ovrEn;
        srcCfg.ovrFst = core_reg.pins.fstBit;
        srcCfg.ovrQck = core_reg.pins.qckBit;
        srcCfg.oeFstLst = ~core_reg.compDis;
        srcCfg.oeQck = ~core_reg.qckDis;
    end

    // Reset brought into the link domain
    always_ff @(posedge linkClk) begin
        lrS1_reg <= rst;
        lrS2_reg <= lrS1_reg;
    end

    assign linkRst = lrS2_reg;

    qs_cfg_cross u_cross (
        .core_clk(core_clk),
        .rst(rst),
        .linkClk(linkClk),
        .linkRst(linkRst),
        .srcCfg(srcCfg),
        .dstCfg(cfg)
    );

    // Line timing edges
    assign dataRise = timing.dataPer & ~link_reg.prevData;
    assign visFall = timing.statusLn & link_reg.prevVis & ~timing.visPix;
    assign stills = cfg.modes.fstMode[1];

    // Link next state
    always_comb begin
        link_next = link_reg;
        link_next.prevData = timing.dataPer;
        link_next.prevVis = timing.visPix;
        // Fast clock at half link rate, slow at quarter
        link_next.fastQ = ~link_reg.fastQ;
        if (link_reg.fastQ) begin
            link_next.slowQ = ~link_reg.slowQ;
        end
        case (link_reg.still)
            ST_IDLE: begin
                if (timing.eofLn) begin
                    link_next.still = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (dataRise && !timing.eofLn) begin
                    link_next.still = ST_ON;
                end
            end
            ST_ON: begin
                if (visFall) begin
                    link_next.still = ST_IDLE;
                end
            end
            default: begin
                link_next.still = ST_IDLE;
            end
        endcase
        if (!stills) begin
            link_next.still = ST_IDLE;
        end
        fieldStrobe = stills ? (link_next.still == ST_ON) :
            (timing.statusLn & timing.visPix);
        case (cfg.modes.qckMode)
            QCK_OFF: qckGate = 1'b0;
            QCK_FREE: qckGate = 1'b1;
            QCK_DATACTL: qckGate = timing.dataPer | timing.ctrlPer;
            QCK_DATA: qckGate = timing.dataPer;
            default: qckGate = 1'b0;
        endcase
        // fast clock for select 01 and 11
        qckClk = cfg.modes.pinSel[0] ? link_next.fastQ : link_next.slowQ;
        link_next.pins.qualifying_clock = qckGate & qckClk;
        // free-running clock on field strobe pin
        if (cfg.modes.pinSel == SEL_FAST_SLOW) begin
            link_next.pins.field_strobe = link_next.fastQ;
        end else if (cfg.modes.pinSel == SEL_INV_FAST) begin
            link_next.pins.field_strobe = ~link_next.fastQ;
        end else begin
            link_next.pins.field_strobe = fieldStrobe;
        end
        if (cfg.ovrEn) begin
            link_next.pins.field_strobe = cfg.ovrFst;
            link_next.pins.qualifying_clock = cfg.ovrQck;
        end
        case (cfg.modes.lstMode)
            LST_OFF: lineSel = 1'b0;
            LST_FREE: lineSel = 1'b1;
            LST_ALL: lineSel = timing.blackLn | timing.videoLn |
                timing.statusLn;
            LST_PIC: lineSel = timing.blackLn | timing.videoLn;
            default: lineSel = 1'b0;
        endcase
        link_next.pins.line_strobe = timing.lineOn & lineSel;
        link_next.pins.fstOe = cfg.oeFstLst;
        link_next.pins.lstOe = cfg.oeFstLst;
        link_next.pins.qckOe = cfg.oeQck;
    end

    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            link_reg <= '{1'b0, 1'b0, 1'b0, 1'b0, ST_IDLE, 6'h00};
        end else begin
            link_reg <= link_next;
        end
    end

    assign pinsOut = link_reg.pins;

    // Core-side checks

    sequence s_pinLow;
        !core_reg.pinS2 && !core_reg.pins.sinEnable;
    endsequence

    sequence s_syncHigh;
        core_reg.pinS2 && core_reg.pins.sinEnable && !regWrite;
    endsequence

    a_pin_reset_regs: assert property (
        @(posedge core_clk) disable iff (rst)
        s_pinLow |=> core_reg.pins == PINS_RST &&
            core_reg.modes.pinSel == SEL_FST_SLOW && timingResync)
        else $error("reset pin did not clear registers");

    a_sync_keeps_regs: assert property (
        @(posedge core_clk) disable iff (rst)
        s_syncHigh |=> $stable(core_reg.pins) && timingResync)
        else $error("sync input disturbed registers");

    a_qck_default: assert property (
        @(posedge core_clk) disable iff (rst)
        !core_reg.qckSet && !regWrite |=>
            core_reg.modes.qckMode == qckDefault($past(videoMode)))
        else $error("clock mode default wrong");

    a_select_reset: assert property (
        @(posedge core_clk) disable iff (rst)
        $fell(rst) |-> core_reg.modes.pinSel == SEL_FST_SLOW)
        else $error("pin select not slow after reset");

    a_comp_disable: assert property (
        @(posedge core_clk) disable iff (rst)
        ##2 1'b1 |-> compositeDisable ==
            ($past(core_reg.oebS1, 2) | $past(fstLstTri)))
        else $error("combined disable wrong");

    a_rsvd_read: assert property (
        @(posedge core_clk) disable iff (rst)
        regAddr == ADDR_RSVD |=> regRdata == RSVD_VAL)
        else $error("reserved slot read not zero");

    a_drive_field: assert property (
        @(posedge core_clk) disable iff (rst)
        regWrite && regAddr == ADDR_PINS && !regClear |=>
            ##1 driveStrength == $past(regWdata[4:3], 2))
        else $error("drive strength not taken");

    // Link-side checks

    sequence s_armStart;
        stills && link_reg.still == ST_ARMED && dataRise &&
            !timing.eofLn;
    endsequence

    sequence s_statusEnd;
        stills && link_reg.still == ST_ON && visFall;
    endsequence

    a_stills_set: assert property (
        @(posedge linkClk) disable iff (linkRst)
        s_armStart ##0 (!cfg.ovrEn && !cfg.modes.pinSel[1])
            |=> pinsOut.field_strobe)
        else $error("stills strobe not set");

    a_stills_clear: assert property (
        @(posedge linkClk) disable iff (linkRst)
        s_statusEnd ##0 (!cfg.ovrEn && !cfg.modes.pinSel[1])
            |=> !pinsOut.field_strobe)
        else $error("stills strobe not cleared");

    a_normal_fst: assert property (
        @(posedge linkClk) disable iff (linkRst)
        !stills && !cfg.ovrEn && !cfg.modes.pinSel[1] |=>
            pinsOut.field_strobe == $past(timing.statusLn & timing.visPix))
        else $error("normal field strobe wrong");

    a_fst_freeclk: assert property (
        @(posedge linkClk) disable iff (linkRst)
        (cfg.modes.pinSel == SEL_FAST_SLOW && !cfg.ovrEn)[*2] |=>
            pinsOut.field_strobe != $past(pinsOut.field_strobe))
        else $error("field strobe pin clock not free running");

    a_fst_invert: assert property (
        @(posedge linkClk) disable iff (linkRst)
        cfg.modes.pinSel == SEL_INV_FAST && !cfg.ovrEn &&
            cfg.modes.qckMode == QCK_FREE |=> pinsOut.field_strobe != pinsOut.qualifying_clock)
        else $error("inverted fast clock wrong");

    a_qck_off: assert property (
        @(posedge linkClk) disable iff (linkRst)
        cfg.modes.qckMode == QCK_OFF && !cfg.ovrEn |=> !pinsOut.qualifying_clock)
        else $error("clock not off");

    a_lst_off: assert property (
        @(posedge linkClk) disable iff (linkRst)
        cfg.modes.lstMode == LST_OFF |=> !pinsOut.line_strobe)
        else $error("line strobe not off");

    a_pin_override: assert property (
        @(posedge linkClk) disable iff (linkRst)
        cfg.ovrEn |=> pinsOut.field_strobe == $past(cfg.ovrFst) &&
            pinsOut.qualifying_clock == $past(cfg.ovrQck))
        else $error("override bits not on pins");

endmodule : qs_pin_select

// ---- verilog/qs_pkg.sv ----
// Summary of operation
// - Pin select 00/01/10/11 routes field strobe and slow or fast clock.
// - Clock on field strobe pin is always the free-running version.
// - Clock mode: off, free-running, data plus control, data only.
// - Clock mode defaults to free-running for PAL/NTSC, off otherwise.
// - Pin select comes out of reset as field strobe plus slow clock.
// - Line strobe mode: off, free, black/video/status, black/video only.
// - Normal field strobe qualifies visible pixels of the status line.
// - Stills mode sets strobe after end-of-frame, clears when status line visible pixels end.
// - Override enable puts register bits 2 and 1 on the pins.
// - Drive field selects 2, 4 or 6 mA; moot while disabled.
// - In reset mode pin low resets registers and resyncs video timing.
// - In sync mode pin high resyncs timing, registers untouched.
// - Combined disable is disable pin or register tri-state bit.
package qs_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_RSVD = 8'h13;
    localparam logic [7:0] ADDR_MODES = 8'h14;
    localparam logic [7:0] ADDR_PINS = 8'h15;

    // Reset values and writable bits
    localparam logic [7:0] MODES_RST = 8'h00;
    localparam logic [7:0] PINS_RST = 8'h00;
    localparam logic [7:0] PINS_WMASK = 8'h3F;
    localparam logic [7:0] RSVD_VAL = 8'h00;

    // Pin select codes
    localparam logic [1:0] SEL_FST_SLOW = 2'h0;
    localparam logic [1:0] SEL_FST_FAST = 2'h1;
    localparam logic [1:0] SEL_FAST_SLOW = 2'h2;
    localparam logic [1:0] SEL_INV_FAST = 2'h3;

    // Clock gating modes
    localparam logic [1:0] QCK_OFF = 2'h0;
    localparam logic [1:0] QCK_FREE = 2'h1;
    localparam logic [1:0] QCK_DATACTL = 2'h2;
    localparam logic [1:0] QCK_DATA = 2'h3;

    // Line strobe modes
    localparam logic [1:0] LST_OFF = 2'h0;
    localparam logic [1:0] LST_FREE = 2'h1;
    localparam logic [1:0] LST_ALL = 2'h2;
    localparam logic [1:0] LST_PIC = 2'h3;

    // Video timing mode code for PAL/NTSC
    localparam logic [1:0] VM_PALNTSC = 2'h1;

    // Mode register layout, bit 7 first
    typedef struct packed {
        logic [1:0] fstMode;
        logic [1:0] lstMode;
        logic [1:0] qckMode;
        logic [1:0] pinSel;
    } qs_modes_type;

    // Override register layout, bit 7 first
    typedef struct packed {
        logic [1:0] unused;
        logic sinEnable;
        logic [1:0] drive;
        logic fstBit;
        logic qckBit;
        logic ovrEn;
    } qs_pins_type;

    // Configuration word carried into the link domain
    typedef struct packed {
        qs_modes_type modes;
        logic ovrEn;
        logic ovrFst;
        logic ovrQck;
        logic oeFstLst;
        logic oeQck;
    } qs_cfg_type;

    localparam qs_cfg_type CFG_RST = 13'h0003;

    // Line timing from the video timing generator
    typedef struct packed {
        logic dataPer;
        logic ctrlPer;
        logic lineOn;
        logic blackLn;
        logic videoLn;
        logic statusLn;
        logic eofLn;
        logic visPix;
    } qs_timing_type;

    // Strobe and clock pins with their enables
    typedef struct packed {
        logic field_strobe;
        logic fstOe;
        logic line_strobe;
        logic lstOe;
        logic qualifying_clock;
        logic qckOe;
    } qs_out_type;

    // Stills strobe sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_ON
    } qs_still_type;

endpackage : qs_pkg

// ---- verilog/qs_cfg_cross.sv ----
`timescale 1ns/100ps
module qs_cfg_cross (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic linkClk,
    input wire logic linkRst,
    input wire qs_pkg::qs_cfg_type srcCfg,
    output qs_pkg::qs_cfg_type dstCfg
);
    import qs_pkg::*;

    typedef struct packed {
        qs_cfg_type hold;
        logic req;
        logic ackS1;
        logic ackS2;
    } qs_src_type;

    typedef struct packed {
        qs_cfg_type cfg;
        logic reqS1;
        logic reqS2;
        logic ack;
    } qs_dst_type;

    qs_src_type src_reg, src_next;
    qs_dst_type dst_reg, dst_next;

    // Source: launch a new word once the last one is acknowledged
    always_comb begin
        src_next = src_reg;
        src_next.ackS1 = dst_reg.ack;
        src_next.ackS2 = src_reg.ackS1;
        if (src_reg.req == src_reg.ackS2 && srcCfg != src_reg.hold) begin
            src_next.hold = srcCfg;
            src_next.req = ~src_reg.req;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            src_reg <= '{CFG_RST, 1'b0, 1'b0, 1'b0};
        end else begin
            src_reg <= src_next;
        end
    end

    // Destination: hold word is stable while request toggle is pending
    always_comb begin
        dst_next = dst_reg;
        dst_next.reqS1 = src_reg.req;
        dst_next.reqS2 = dst_reg.reqS1;
        if (dst_reg.reqS2 != dst_reg.ack) begin
            dst_next.cfg = src_reg.hold;
            dst_next.ack = dst_reg.reqS2;
        end
    end

    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            dst_reg <= '{CFG_RST, 1'b0, 1'b0, 1'b0};
        end else begin
            dst_reg <= dst_next;
        end
    end

    assign dstCfg = dst_reg.cfg;

endmodule : qs_cfg_cross

// ---- tb/qs_grabber_model.sv ----
`timescale 1ns/100ps
module qs_grabber_model (
    input wire logic linkClk,
    input wire qs_pkg::qs_out_type pinsOut,
    output logic fstWire,
    output logic lstWire,
    output logic qckWire
);
    import qs_pkg::*;
    logic fstLast_reg;
    logic lstLast_reg;
    logic qckLast_reg;
    // Remember the last level each pin was driven to
    always_ff @(posedge linkClk) begin
        if (pinsOut.fstOe) fstLast_reg <= pinsOut.field_strobe;
        if (pinsOut.lstOe) lstLast_reg <= pinsOut.line_strobe;
        if (pinsOut.qckOe) qckLast_reg <= pinsOut.qualifying_clock;
    end
    // Released pins float away from the last driven level
    assign fstWire = pinsOut.fstOe ? pinsOut.field_strobe : ~fstLast_reg;
    assign lstWire = pinsOut.lstOe ? pinsOut.line_strobe : ~lstLast_reg;
    assign qckWire = pinsOut.qckOe ? pinsOut.qualifying_clock : ~qckLast_reg;
endmodule : qs_grabber_model

// ---- tb/test_video_qualifier_pin_select.sv ----
`timescale 1ns/100ps
module test_video_qualifier_pin_select;
    import qs_pkg::*;
    logic core_clk = 1'b0;
    logic linkClk = 1'b0;
    logic rst = 1'b1;
    logic regWrite = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic [1:0] videoMode = 2'h0;
    logic fstLstTri = 1'b0;
    logic qckTri = 1'b0;
    logic resetSyncPin = 1'b1;
    logic outDisablePin = 1'b0;
    qs_timing_type timing = '0;
    logic [7:0] regRdata;
    logic timingResync;
    logic registerClear;
    logic compositeDisable;
    logic [1:0] driveStrength;
    qs_out_type pinsOut;
    logic fstWire;
    logic lstWire;
    logic qckWire;
    int failCount = 0;
    int nChecks = 0;
    int nq;
    int nf;
    int ne;
    // Mode word, timing, expected {qck toggles, fst toggles, lst level}
    logic [7:0] tm [17] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h03, 8'h02,
        8'h00, 8'h0D, 8'h0D, 8'h09, 8'h09, 8'h10, 8'h00, 8'h20, 8'h30,
        8'h30, 8'h20};
    logic [7:0] tt [17] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h80, 8'h40, 8'h40, 8'h00, 8'h20, 8'h24, 8'h24, 8'h24,
        8'h30, 8'h28};
    logic [11:0] tx [17] = '{12'h400, 12'h800, 12'h480, 12'h880,
        12'h080, 12'h080, 12'h000, 12'h800, 12'h000, 12'h800, 12'h000,
        12'h001, 12'h000, 12'h001, 12'h000, 12'h001, 12'h001};

    // Core clock
    always #2.5 core_clk = ~core_clk;

    // Link clock, offset in phase
    initial begin
        #13;
        forever #40 linkClk = ~linkClk;
    end

    qs_pin_select DUT (.core_clk(core_clk), .rst(rst), .regWrite(regWrite),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .videoMode(videoMode), .fstLstTri(fstLstTri), .qckTri(qckTri),
        .resetSyncPin(resetSyncPin), .outDisablePin(outDisablePin),
        .timingResync(timingResync), .registerClear(registerClear),
        .compositeDisable(compositeDisable),
        .driveStrength(driveStrength), .linkClk(linkClk),
        .timing(timing), .pinsOut(pinsOut));

    qs_grabber_model grabber (.linkClk(linkClk), .pinsOut(pinsOut),
        .fstWire(fstWire), .lstWire(lstWire), .qckWire(qckWire));

    task stopTest;
        $display("checks %0d, mismatches %0d", nChecks, failCount);
        if (failCount == 0 && nChecks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stopTest

    task chk(input logic [7:0] got, input logic [7:0] exp);
        nChecks++;
        if (got !== exp) begin
            failCount++;
            $display("unexpected at %0t: got %h, expected %h", $time, got,
                exp);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        regAddr <= a;
        @(posedge core_clk);
        @(negedge core_clk);
        chk(regRdata, e);
    endtask : rd

    task cw(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cw

    task lw(input int n);
        repeat (n) @(negedge linkClk);
    endtask : lw

    task setCfg(input logic [7:0] a, input logic [7:0] d);
        wr(a, d);
        lw(8);
    endtask : setCfg

    task tim(input logic [7:0] t);
        @(posedge linkClk);
        timing <= qs_timing_type'(t);
        lw(2);
    endtask : tim

    // Count pin changes over eight link cycles
    task toggles;
        logic pq;
        logic pf;
        nq = 0;
        nf = 0;
        ne = 0;
        @(negedge linkClk);
        pq = qckWire;
        pf = fstWire;
        repeat (8) begin
            @(negedge linkClk);
            if (qckWire !== pq) nq++;
            if (fstWire !== pf) nf++;
            if (fstWire === qckWire) ne++;
            pq = qckWire;
            pf = fstWire;
        end
    endtask : toggles

    // Hang guard
    initial begin
        #100000;
        failCount++;
        stopTest();
    end

    initial begin
        repeat (5) @(posedge linkClk);
        @(posedge core_clk);
        rst <= 1'b0;
        lw(10);
        rd(8'h14, 8'h00);
        rd(8'h15, 8'h00);
        chk(8'(driveStrength), 8'h00);
        chk(8'({pinsOut.fstOe, pinsOut.lstOe, pinsOut.qckOe}), 8'h07);
        for (int i = 0; i < 17; i++) begin
            @(posedge linkClk);
            timing <= qs_timing_type'(tt[i]);
            setCfg(8'h14, tm[i]);
            toggles();
            chk(8'(nq), 8'(tx[i][11:8]));
            chk(8'(nf), 8'(tx[i][7:4]));
            chk(8'(lstWire), 8'(tx[i][0]));
            if (i == 3) chk(8'(ne), 8'h00);
        end
        setCfg(8'h14, 8'h00);
        tim(8'h05);
        chk(8'(pinsOut.field_strobe), 8'h01);
        tim(8'h04);
        chk(8'(pinsOut.field_strobe), 8'h00);
        setCfg(8'h14, 8'h80);
        tim(8'h02);
        tim(8'h00);
        chk(8'(pinsOut.field_strobe), 8'h00);
        tim(8'h80);
        chk(8'(pinsOut.field_strobe), 8'h01);
        tim(8'h05);
        chk(8'(pinsOut.field_strobe), 8'h01);
        tim(8'h04);
        chk(8'(pinsOut.field_strobe), 8'h00);
        setCfg(8'h15, 8'h05);
        chk(8'({pinsOut.field_strobe, pinsOut.qualifying_clock}), 8'h02);
        setCfg(8'h15, 8'h03);
        chk(8'({pinsOut.field_strobe, pinsOut.qualifying_clock}), 8'h01);
        for (int d = 0; d < 4; d++) begin
            wr(8'h15, 8'(d << 3));
            cw(3);
            chk(8'(driveStrength), 8'(d));
            rd(8'h15, 8'(d << 3));
        end
        wr(8'h13, 8'hFF);
        rd(8'h13, 8'h00);
        wr(8'h15, 8'hFF);
        rd(8'h15, 8'h3F);
        wr(8'h15, 8'h20);
        cw(6);
        chk(8'({timingResync, registerClear}), 8'h02);
        rd(8'h15, 8'h20);
        wr(8'h15, 8'h18);
        videoMode <= VM_PALNTSC;
        @(posedge core_clk);
        resetSyncPin <= 1'b0;
        cw(6);
        chk(8'({timingResync, registerClear}), 8'h03);
        wr(8'h15, 8'h08);
        rd(8'h15, 8'h00);
        rd(8'h14, 8'h04);
        @(posedge core_clk);
        resetSyncPin <= 1'b1;
        cw(6);
        chk(8'({timingResync, registerClear}), 8'h00);
        @(posedge core_clk);
        outDisablePin <= 1'b1;
        cw(6);
        chk(8'(compositeDisable), 8'h01);
        lw(8);
        chk(8'({pinsOut.fstOe, pinsOut.lstOe, pinsOut.qckOe}), 8'h00);
        @(posedge core_clk);
        outDisablePin <= 1'b0;
        fstLstTri <= 1'b1;
        cw(6);
        chk(8'(compositeDisable), 8'h01);
        lw(8);
        chk(8'({pinsOut.fstOe, pinsOut.lstOe, pinsOut.qckOe}), 8'h01);
        @(posedge core_clk);
        fstLstTri <= 1'b0;
        qckTri <= 1'b1;
        cw(6);
        chk(8'(compositeDisable), 8'h00);
        lw(8);
        chk(8'({pinsOut.fstOe, pinsOut.lstOe, pinsOut.qckOe}), 8'h06);
        stopTest();
    end
endmodule : test_video_qualifier_pin_select
